// ---- hdl/dpca_host.sv ----
// module: host controller driving one port of a contention-arbitrated RAM
//
// Behaviour
// - slave stall input precedes write strobe
// - hold write strobe after stall release
// - stalled read data not trusted
// - timing identical on left and right
// - stall-release-to-data delay is computed maximum
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module dpca_host #(
   parameter int ADDR_W = 11,
   parameter int DATA_W = 8
) (
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // ram port pins
   output dpca_pkg::dpca_port_ctl_type   port_ctl,
   output logic      [DATA_W-1:0]        data_out,
   output logic                          data_oe_n,
   input  wire logic [DATA_W-1:0]        data_in,
   input  wire logic                     stall_n,
   // interrupt
   output logic                          irq
);

   // ************************************************************
   // register bus decode
   // ************************************************************
   dpca_pkg::dpca_state_type state_q, state_d;
   logic        wr_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q, rdata_q;
   logic [dpca_pkg::EVT_W-1:0] status_q, mask_q;
   logic [7:0]  cnt_q;
   logic        stalled_q;

   wire access   = psel & penable;
   wire wr_acc   = access & pwrite;
   wire hit_ctrl = wr_acc & (paddr == dpca_pkg::REG_CTRL);
   wire go       = hit_ctrl & pwdata[dpca_pkg::CTRL_GO_BIT]
                   & (state_q == dpca_pkg::ST_IDLE);
   wire busy     = (state_q != dpca_pkg::ST_IDLE);
   wire mapped   = (paddr <= dpca_pkg::REG_STATE) & (paddr[1:0] == 2'b00);
   wire cnt_zero = (cnt_q == 8'h00);
   wire done_evt = (state_q == dpca_pkg::ST_END);
   wire stall_evt = ~stall_n & busy & ~stalled_q;

   assign pready  = 1'b1;   // every access completes in its access cycle
   assign pslverr = access & ~mapped;
   assign irq     = |(status_q & mask_q);

   // read mux
   always_comb begin
      case (paddr)
         dpca_pkg::REG_CTRL:   prdata = {30'h0, wr_q, busy};
         dpca_pkg::REG_ADDR:   prdata = {21'h0, addr_q};
         dpca_pkg::REG_WDATA:  prdata = {24'h0, wdata_q};
         dpca_pkg::REG_RDATA:  prdata = {24'h0, rdata_q};
         dpca_pkg::REG_STATUS: prdata = {30'h0, status_q};
         dpca_pkg::REG_MASK:   prdata = {30'h0, mask_q};
         dpca_pkg::REG_STATE:  prdata = {31'h0, busy};
         default:              prdata = dpca_pkg::RESET_WORD;
      endcase
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   // address and data frozen while a cycle runs so pins stay stable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_q    <= 1'b0;
         addr_q  <= 11'h000;
         wdata_q <= 8'h00;
         mask_q  <= 2'h0;
      end else begin
         if (hit_ctrl && !busy)
            wr_q <= pwdata[dpca_pkg::CTRL_WR_BIT];
         if (wr_acc && paddr == dpca_pkg::REG_ADDR && !busy)
            addr_q <= pwdata[ADDR_W-1:0];
         if (wr_acc && paddr == dpca_pkg::REG_WDATA && !busy)
            wdata_q <= pwdata[DATA_W-1:0];
         if (wr_acc && paddr == dpca_pkg::REG_MASK)
            mask_q <= pwdata[dpca_pkg::EVT_W-1:0];
      end
   end

   // sticky events; a set in the clearing cycle wins
   wire [dpca_pkg::EVT_W-1:0] evt_set = {stall_evt, done_evt};
   wire [dpca_pkg::EVT_W-1:0] evt_clr =
      (wr_acc && paddr == dpca_pkg::REG_STATUS) ?
      pwdata[dpca_pkg::EVT_W-1:0] : 2'h0;
   always_ff @(posedge sys_clk) begin
      if (rst)
         status_q <= 2'h0;
      else
         status_q <= (status_q & ~evt_clr) | evt_set;
   end

   // ************************************************************
   // port sequencer
   // ************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         dpca_pkg::ST_IDLE:  if (go) state_d = dpca_pkg::ST_SETUP;
         // stall before strobe
         // let the ram settle its stall decision before strobing
         dpca_pkg::ST_SETUP: if (cnt_zero)
            state_d = wr_q ? dpca_pkg::ST_WRITE : dpca_pkg::ST_READ;
         dpca_pkg::ST_WRITE: if (cnt_zero && stall_n)
            state_d = dpca_pkg::ST_HOLD;
         dpca_pkg::ST_HOLD:  if (cnt_zero) state_d = dpca_pkg::ST_END;
         dpca_pkg::ST_READ:  if (cnt_zero && stall_n)
            state_d = dpca_pkg::ST_RWAIT;
         dpca_pkg::ST_RWAIT: if (cnt_zero) state_d = dpca_pkg::ST_END;
         dpca_pkg::ST_END:   state_d = dpca_pkg::ST_IDLE;
         default:            state_d = dpca_pkg::ST_IDLE;
      endcase
   end

   // counts are whole clocks, rounded up from the nanosecond figures
   // cycle counter per state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= dpca_pkg::ST_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_d != state_q)
            case (state_d)
               dpca_pkg::ST_SETUP: cnt_q <= 8'(dpca_pkg::TBAA_CYC - 1);
               dpca_pkg::ST_WRITE: cnt_q <= 8'(dpca_pkg::TWP_CYC - 1);
               dpca_pkg::ST_HOLD:  cnt_q <= 8'(dpca_pkg::TWH_CYC - 1);
               dpca_pkg::ST_READ:  cnt_q <= 8'(dpca_pkg::TAA_CYC - 1);
               dpca_pkg::ST_RWAIT: cnt_q <= 8'(dpca_pkg::TBDD_CYC - 1);
               default:            cnt_q <= 8'h00;
            endcase
         else if (!cnt_zero)
            cnt_q <= cnt_q - 8'h01;
      end
   end

   // stall seen in this cycle; counted once per cycle
   always_ff @(posedge sys_clk) begin
      if (rst)
         stalled_q <= 1'b0;
      else if (!busy)
         stalled_q <= 1'b0;
      else if (!stall_n)
         stalled_q <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         rdata_q <= 8'h00;
      else if (state_q == dpca_pkg::ST_RWAIT && cnt_zero)
         rdata_q <= data_in;
   end

   // ************************************************************
   // pin drive
   // ************************************************************
   // phases of the coming cycle; pins are registered from the next state
   wire strobe  = (state_d == dpca_pkg::ST_WRITE) |
                  (state_d == dpca_pkg::ST_HOLD);
   wire rd_ph   = (state_d == dpca_pkg::ST_READ) |
                  (state_d == dpca_pkg::ST_RWAIT);
   wire sel_ph  = (state_d != dpca_pkg::ST_IDLE) &
                  (state_d != dpca_pkg::ST_END);
   // wr_q updates on the go edge itself, so take the bit from the bus
   wire wr_next = go ? pwdata[dpca_pkg::CTRL_WR_BIT] : wr_q;
   // data released with the select, so no drive while deselected
   wire drive   = sel_ph & wr_next;

   // no side-specific state
   // one copy of this controller serves either port unchanged
   // deselect when idle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         port_ctl  <= '{cs_n: 1'b1, oe_n: 1'b1, rw: 1'b1, addr: 11'h000};
         data_out  <= 8'h00;
         data_oe_n <= 1'b1;
      end else begin
         port_ctl.cs_n <= ~sel_ph;
         port_ctl.rw   <= ~strobe;
         port_ctl.oe_n <= ~rd_ph;
         port_ctl.addr <= addr_q;
         data_out      <= wdata_q;
         data_oe_n     <= ~drive;
      end
   end

endmodule

// ---- pkg/dpca_pkg.sv ----
// package: constants and types for the dual-port contention host controller
package dpca_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int TWH_NS          = 12;   // write hold after stall release
   localparam int TWP_NS          = 20;   // write pulse width
   localparam int TBAA_NS         = 20;   // stall access from address
   localparam int TBDD_NS         = 30;   // stall release to valid data
   localparam int TAA_NS          = 25;   // read access
   localparam int TWH_CYC  = (TWH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TWP_CYC  = (TWP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TBAA_CYC = (TBAA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TBDD_CYC = (TBDD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TAA_CYC  = (TAA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ************************************************************
   // register map (byte offsets)
   // ************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00; // [0] go, [1] write
   localparam logic [7:0] REG_ADDR   = 8'h04; // [10:0]
   localparam logic [7:0] REG_WDATA  = 8'h08; // [7:0]
   localparam logic [7:0] REG_RDATA  = 8'h0C; // [7:0]
   localparam logic [7:0] REG_STATUS = 8'h10; // [0] done [1] stalled
   localparam logic [7:0] REG_MASK   = 8'h14;
   localparam logic [7:0] REG_STATE  = 8'h18; // [0] busy
   localparam int CTRL_GO_BIT  = 0;
   localparam int CTRL_WR_BIT  = 1;
   localparam int EVT_DONE_BIT = 0;
   localparam int EVT_STALL_BIT = 1;
   localparam int EVT_W        = 2;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic        cs_n;
      logic        oe_n;
      logic        rw;     // high read, low write
      logic [10:0] addr;
   } dpca_port_ctl_type;

   typedef enum {
      ST_IDLE, ST_SETUP, ST_WRITE, ST_HOLD, ST_READ, ST_RWAIT, ST_END
   } dpca_state_type;

endpackage

// ---- verif/dpca_host_props.sv ----
// checker: pin timing of the contention host controller
`timescale 1ns/1ps
module dpca_host_props (
   // clock and reset
   input wire logic                        sys_clk,
   input wire logic                        rst,
   // ram port pins
   input wire dpca_pkg::dpca_port_ctl_type port_ctl,
   input wire logic                        data_oe_n,
   input wire logic                        stall_n
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // decoded port state, so each property fits on one line
   wire cs    = !port_ctl.cs_n;
   wire wr    = cs && !port_ctl.rw;
   wire rd_on = cs && !port_ctl.oe_n;
   // strobes and drivers against select and stall
   idle_rst_a: assert property ($fell(rst) |-> !cs && data_oe_n)
      else $error("port not idle after reset");
   desel_a: assert property (!cs |-> data_oe_n)
      else $error("data driven while deselected");
   no_clash_a: assert property (!port_ctl.oe_n |-> data_oe_n)
      else $error("host drives during read");
   setup_a: assert property ($rose(cs) |-> port_ctl.rw[*5])
      else $error("strobe inside address setup");
   pulse_a: assert property ($rose(wr) |-> wr[*5])
      else $error("write pulse too short");
   blocked_a: assert property (wr && !stall_n |=> wr)
      else $error("strobe dropped while stalled");
   hold_a: assert property ($rose(stall_n) && wr |=> wr[*2])
      else $error("write hold after release short");
   read_wait_a: assert property (rd_on && !stall_n |=> rd_on)
      else $error("read ended while stalled");
endmodule
bind dpca_host dpca_host_props chk (.sys_clk(sys_clk), .rst(rst),
   .port_ctl(port_ctl), .data_oe_n(data_oe_n), .stall_n(stall_n));

// ---- verif/dpca_ram_model.sv ----
// model: one ram port whose far side may win contention
`timescale 1ns/1ps
module dpca_ram_model (
   // clock
   input  wire logic                        sys_clk,
   // host pins
   input  wire dpca_pkg::dpca_port_ctl_type port_ctl,
   input  wire logic [7:0]                  data_out,
   input  wire logic                        data_oe_n,
   output logic      [7:0]                  data_in,
   output logic                             stall_n,
   // contention length set by the bench
   input  wire logic [7:0]                  stall_len
);
   logic [7:0] mem [0:2047];
   logic [7:0] cnt_q  = 8'h00;
   logic [7:0] last_q = 8'h00;
   wire        rd_on  = !port_ctl.cs_n && port_ctl.rw && !port_ctl.oe_n;
   assign stall_n = (cnt_q == 8'h00);
   // junk unless read valid, never a stale value
   assign data_in = (rd_on && stall_n) ? mem[port_ctl.addr] : ~last_q;
   // far port wins at select, whatever the direction
   always_ff @(posedge sys_clk) begin
      last_q <= data_in;
      if (port_ctl.cs_n)
         cnt_q <= 8'h00;
      else if ($fell(port_ctl.cs_n))
         cnt_q <= stall_len;
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
      if (!port_ctl.cs_n && !port_ctl.rw && stall_n)
         mem[port_ctl.addr] <= data_oe_n ? ~data_out : data_out;
   end
endmodule

// ---- verif/dpca_host_test.sv ----
// bench: host controller over apb against a ram port model
`timescale 1ns/1ps
module dpca_host_test;
   logic        sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, pready, pslverr, data_oe_n, stall_n, irq, err;
   logic [7:0]  paddr = 8'h00, stall_len = 8'h00, data_out, data_in;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          fails = 0, n_checks = 0, i;
   dpca_pkg::dpca_port_ctl_type port_ctl;
   localparam logic [7:0] R_ST = dpca_pkg::REG_STATUS;
   localparam logic [7:0] R_RD = dpca_pkg::REG_RDATA;
   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;
   dpca_host dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_ctl(port_ctl), .data_out(data_out), .data_oe_n(data_oe_n),
      .data_in(data_in), .stall_n(stall_n), .irq(irq));
   dpca_ram_model ram (.sys_clk(sys_clk), .port_ctl(port_ctl),
      .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
      .stall_n(stall_n), .stall_len(stall_len));
   // counts, verdict and stop
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // a wait ran out: count it and stop
   task automatic bail();
      fails++;
      end_sim();
   endtask
   // one word comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; data taken at the ready edge only
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      for (k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         if (pready === 1'h1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (k == 20) bail();
   endtask
   // register read against an expected word
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask
   // poll until the ram access is over, bounded
   task automatic idle();
      for (i = 0; i < 100; i++) begin
         apb(1'h0, dpca_pkg::REG_STATE, 32'h0);
         if (rd[0] === 1'h0) break;
      end
      if (i == 100) bail();
   endtask
   // start a ram access, optionally wait for its end
   task automatic go(input logic w, input logic [10:0] a,
                     input logic [7:0] d, input logic wt);
      apb(1'h1, dpca_pkg::REG_ADDR, {21'h0, a});
      apb(1'h1, dpca_pkg::REG_WDATA, {24'h0, d});
      apb(1'h1, dpca_pkg::REG_CTRL, {30'h0, w, 1'h1});
      if (wt) idle();
   endtask
   // scenarios in order; status is carried from one to the next
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'h0;
      rchk(R_ST, 32'h0);
      rchk(dpca_pkg::REG_STATE, 32'h0);
      $display("test reset done");
      go(1'h1, 11'h7FF, 8'hA5, 1'h1);
      rchk(R_ST, 32'h1);
      go(1'h0, 11'h7FF, 8'h00, 1'h1);
      rchk(R_RD, 32'hA5);
      apb(1'h1, R_ST, 32'h3);
      rchk(R_ST, 32'h0);
      $display("test plain access done");
      stall_len <= 8'h14;
      go(1'h1, 11'h000, 8'h3C, 1'h1);
      rchk(R_ST, 32'h3);
      stall_len <= 8'h00;
      go(1'h0, 11'h000, 8'h00, 1'h1);
      rchk(R_RD, 32'h3C);
      stall_len <= 8'h0A;
      go(1'h0, 11'h7FF, 8'h00, 1'h1);
      rchk(R_RD, 32'hA5);
      $display("test stalled access done");
      apb(1'h1, dpca_pkg::REG_MASK, 32'h2);
      rchk(dpca_pkg::REG_MASK, 32'h2);
      chk({31'h0, irq}, 32'h1);
      apb(1'h1, R_ST, 32'h2);
      rchk(R_ST, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'h0, 8'h40, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      $display("test interrupt and map done");
      stall_len <= 8'h14;
      go(1'h1, 11'h001, 8'h11, 1'h0);
      apb(1'h1, dpca_pkg::REG_WDATA, 32'h22);
      idle();
      go(1'h0, 11'h001, 8'h00, 1'h1);
      rchk(R_RD, 32'h11);
      $display("test busy refusal done");
      end_sim();
   end
endmodule
